// file: rtl/art_pkg.sv
// package: register map, field layout and encodings of the aperture translator
package art_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_BASE_LOW   = 8'h00;
   localparam logic [7:0] OFS_BASE_HIGH  = 8'h04;
   localparam logic [7:0] OFS_SIZE_SEL   = 8'h08;
   localparam logic [7:0] OFS_CONTROL    = 8'h0c;
   localparam logic [7:0] OFS_STATUS     = 8'h10;
   localparam logic [7:0] OFS_COMMAND    = 8'h14;
   localparam logic [7:0] OFS_PAGE_SEL   = 8'h18;
   localparam logic [7:0] OFS_TBL_LOW    = 8'h1c;
   localparam logic [7:0] OFS_TBL_HIGH   = 8'h20;
   localparam logic [7:0] OFS_ERR_FLAGS  = 8'h24;
   localparam logic [7:0] OFS_ERR_ADDR_L = 8'h28;
   localparam logic [7:0] OFS_ERR_ADDR_H = 8'h2c;
   localparam logic [7:0] OFS_HITS       = 8'h30;
   // control bits
   localparam int CTL_APER_EN  = 0;
   localparam int CTL_CACHE_EN = 1;
   // status bits (port_status)
   localparam int STA_WIDE_OK    = 0;
   localparam int STA_HTRANS_B   = 1;
   localparam int STA_ITA_COH    = 2;
   localparam int STA_ABOVE_4GB  = 3;
   localparam int STA_PAGES_LSB  = 8;
   // command bits (port_command)
   localparam int CMD_WIDE       = 0;
   // entry fields
   localparam int ENT_VALID = 0;
   localparam int ENT_COH   = 1;
   // table alignment mask
   localparam logic [31:0] TBL_ALIGN_MASK = 32'hfffff000;
   // aperture size select: code n means 4 MB << n, max code 8 (1 GB)
   localparam logic [3:0]  SIZE_MAX    = 4'h8;
   localparam int          SIZE_LOG2_0 = 22;
   // page select: 0 = 4 KB (reset), 1 = 64 KB, 2 = 4 MB
   localparam logic [1:0]  PG_4K       = 2'h0;
   localparam logic [1:0]  PG_64K      = 2'h1;
   localparam logic [1:0]  PG_4M       = 2'h2;
   localparam logic [2:0]  PG_SUPPORT  = 3'h7;
   localparam int          PG_LOG2_4K  = 12;
   localparam int          PG_LOG2_64K = 16;
   localparam int          PG_LOG2_4M  = 22;
   // entry size log2
   localparam logic [1:0]  M_NARROW = 2'h2;
   localparam logic [1:0]  M_WIDE   = 2'h3;
   // axi responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // translator states
   typedef enum logic [1:0] {
      ART_IDLE  = 2'b00,
      ART_FETCH = 2'b01,
      ART_WAIT  = 2'b11,
      ART_DONE  = 2'b10
   } art_state_t;
endpackage : art_pkg

// file: rtl/art_top.sv
// aperture remapping translator with one-entry cache and axi4-lite registers
`timescale 1ns/1ns
module art_top (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // master access request
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [63:0] req_addr,
   input  wire logic        req_write,
   // translated access out
   output logic             out_valid,
   output logic [63:0]      out_addr,
   output logic             out_write,
   output logic             out_coherent,
   output logic             out_cancel,
   // entry fetch from memory
   output logic             fetch_valid,
   output logic [63:0]      fetch_addr,
   input  wire logic        fetch_done,
   input  wire logic [63:0] fetch_data,
   // host alert
   output logic             error_alert
);
   //////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic                aw_got;
      logic [7:0]          aw_addr;
      logic                w_got;
      logic [31:0]         w_data;
      logic [3:0]          w_strb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic [31:0]         base_lo;
      logic [31:0]         base_hi;
      logic [3:0]          size_sel;
      logic                aper_en;
      logic                cache_en;
      logic                wide;
      logic [1:0]          pg_sel;
      logic [31:0]         tbl_lo;
      logic [31:0]         tbl_hi;
      logic                err;
      logic [63:0]         err_addr;
      logic [31:0]         hits;
      art_pkg::art_state_t st;
      logic [63:0]         cur_addr;
      logic                cur_write;
      logic [63:0]         cur_ent_addr;
      logic                c_valid;
      logic [63:0]         c_tag;
      logic [63:0]         c_data;
      logic                o_valid;
      logic [63:0]         o_addr;
      logic                o_write;
      logic                o_coh;
      logic                o_cancel;
      logic                f_valid;
      logic                alert;
   } art_state_s_t;

   art_state_s_t q, d;

   // page size log2 from selector
   function automatic logic [5:0] pg_log2(input logic [1:0] sel);
      unique case (sel)
         art_pkg::PG_64K: pg_log2 = 6'(art_pkg::PG_LOG2_64K);
         art_pkg::PG_4M:  pg_log2 = 6'(art_pkg::PG_LOG2_4M);
         default:         pg_log2 = 6'(art_pkg::PG_LOG2_4K);
      endcase
   endfunction : pg_log2

   // aperture mask of low bits forced to zero
   function automatic logic [63:0] size_mask(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > art_pkg::SIZE_MAX) ? art_pkg::SIZE_MAX : sel;
      size_mask = (64'h1 << (6'(art_pkg::SIZE_LOG2_0) + 6'(s))) - 64'h1;
   endfunction : size_mask

   // frame number from entry
   function automatic logic [63:0] entry_frame(input logic [63:0] e, input logic wd);
      entry_frame = {4'h0, (wd ? e[63:32] : 32'h0), e[11:4], e[31:12]};
   endfunction : entry_frame

   //////////////////////////////////////////////////////////////////////////
   logic [63:0] aper_base;
   logic [63:0] amask;
   logic [63:0] tbl_start;
   logic [63:0] offs;
   logic [63:0] ent_addr;
   logic        in_aper;
   logic [5:0]  plog;
   logic [63:0] frame;
   logic [63:0] ent_use;

   always_comb begin
      amask     = size_mask(q.size_sel);
      aper_base = {q.base_hi, q.base_lo} & ~amask;
      tbl_start = {q.tbl_hi, 32'h0} + {32'h0, q.tbl_lo & art_pkg::TBL_ALIGN_MASK};
      plog      = pg_log2(q.pg_sel);
      offs      = req_addr - aper_base;
      in_aper   = q.aper_en && ((req_addr & ~amask) == aper_base);
      ent_addr  = tbl_start + ((offs >> plog) << (q.wide ? art_pkg::M_WIDE
                                                          : art_pkg::M_NARROW));
      ent_use   = q.c_data;
      frame     = entry_frame(ent_use, q.wide);
   end

   //////////////////////////////////////////////////////////////////////////
   logic [31:0] rd_val;
   logic [31:0] wmask;
   logic        w_hit;

   always_comb begin
      d = q;
      d.alert = 1'b0;
      d.o_valid = 1'b0;
      // register write
      if (s_axi_awvalid && !q.aw_got) begin
         d.aw_got  = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_got) begin
         d.w_got  = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{q.w_strb[i]}};
      end
      w_hit = 1'b1;
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = art_pkg::RESP_OKAY;
         unique case (q.aw_addr)
            art_pkg::OFS_BASE_LOW:  d.base_lo = (q.base_lo & ~wmask) | (q.w_data & wmask);
            art_pkg::OFS_BASE_HIGH: d.base_hi = (q.base_hi & ~wmask) | (q.w_data & wmask);
            art_pkg::OFS_SIZE_SEL:  if (q.w_strb[0]) d.size_sel = q.w_data[3:0];
            art_pkg::OFS_CONTROL: begin
               if (q.w_strb[0]) begin
                  d.aper_en  = q.w_data[art_pkg::CTL_APER_EN];
                  d.cache_en = q.w_data[art_pkg::CTL_CACHE_EN];
               end
            end
            art_pkg::OFS_COMMAND:   if (q.w_strb[0]) d.wide = q.w_data[art_pkg::CMD_WIDE];
            art_pkg::OFS_PAGE_SEL: begin
               if (q.w_strb[0] && q.w_data[1:0] <= art_pkg::PG_4M)
                  d.pg_sel = q.w_data[1:0];
            end
            art_pkg::OFS_TBL_LOW:   d.tbl_lo = (q.tbl_lo & ~wmask) | (q.w_data & wmask);
            art_pkg::OFS_TBL_HIGH:  d.tbl_hi = (q.tbl_hi & ~wmask) | (q.w_data & wmask);
            art_pkg::OFS_ERR_FLAGS: if (q.w_strb[0] && q.w_data[0]) d.err = 1'b0;
            art_pkg::OFS_STATUS, art_pkg::OFS_ERR_ADDR_L, art_pkg::OFS_ERR_ADDR_H,
            art_pkg::OFS_HITS: ;
            default: w_hit = 1'b0;
         endcase
         if (!w_hit)
            d.bresp = art_pkg::RESP_SLVERR;
      end
      if (q.bvalid && s_axi_bready)
         d.bvalid = 1'b0;
      // register read
      rd_val = 32'h0;
      unique case (s_axi_araddr)
         art_pkg::OFS_BASE_LOW:   rd_val = aper_base[31:0];
         art_pkg::OFS_BASE_HIGH:  rd_val = aper_base[63:32];
         art_pkg::OFS_SIZE_SEL:   rd_val = {28'h0, q.size_sel};
         art_pkg::OFS_CONTROL:    rd_val = {30'h0, q.cache_en, q.aper_en};
         art_pkg::OFS_STATUS: begin
            rd_val[art_pkg::STA_WIDE_OK]   = 1'b1;
            rd_val[art_pkg::STA_HTRANS_B]  = 1'b1;
            rd_val[art_pkg::STA_ITA_COH]   = 1'b1;
            rd_val[art_pkg::STA_ABOVE_4GB] = 1'b1;
            rd_val[art_pkg::STA_PAGES_LSB +: 3] = art_pkg::PG_SUPPORT;
         end
         art_pkg::OFS_COMMAND:    rd_val = {31'h0, q.wide};
         art_pkg::OFS_PAGE_SEL:   rd_val = {30'h0, q.pg_sel};
         art_pkg::OFS_TBL_LOW:    rd_val = q.tbl_lo & art_pkg::TBL_ALIGN_MASK;
         art_pkg::OFS_TBL_HIGH:   rd_val = q.tbl_hi;
         art_pkg::OFS_ERR_FLAGS:  rd_val = {31'h0, q.err};
         art_pkg::OFS_ERR_ADDR_L: rd_val = q.err_addr[31:0];
         art_pkg::OFS_ERR_ADDR_H: rd_val = q.err_addr[63:32];
         art_pkg::OFS_HITS:       rd_val = q.hits;
         default:                 rd_val = 32'h0;
      endcase
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_val;
         d.rresp  = (s_axi_araddr <= art_pkg::OFS_HITS && s_axi_araddr[1:0] == 2'h0)
                    ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // cache dropped while disabled
      if (!q.cache_en)
         d.c_valid = 1'b0;
      // translation engine
      unique case (q.st)
         art_pkg::ART_IDLE: begin
            if (req_valid) begin
               d.cur_addr  = req_addr;
               d.cur_write = req_write;
               if (in_aper) begin
                  d.cur_ent_addr = ent_addr;
                  if (q.cache_en && q.c_valid && q.c_tag == ent_addr) begin
                     d.st   = art_pkg::ART_DONE;
                     d.hits = q.hits + 32'h1;
                  end else begin
                     d.st      = art_pkg::ART_FETCH;
                     d.f_valid = 1'b1;
                  end
               end else begin
                  d.o_valid  = 1'b1;
                  d.o_addr   = req_addr;
                  d.o_write  = req_write;
                  d.o_coh    = 1'b1;
                  d.o_cancel = 1'b0;
               end
            end
         end
         art_pkg::ART_FETCH, art_pkg::ART_WAIT: begin
            d.st = art_pkg::ART_WAIT;
            if (fetch_done) begin
               d.f_valid = 1'b0;
               d.c_data  = fetch_data;
               d.c_tag   = q.cur_ent_addr;
               d.c_valid = q.cache_en;
               d.st      = art_pkg::ART_DONE;
            end
         end
         art_pkg::ART_DONE: begin
            d.st      = art_pkg::ART_IDLE;
            d.o_valid = 1'b1;
            d.o_write = q.cur_write;
            d.o_addr  = (frame << plog) | (q.cur_addr & ((64'h1 << plog) - 64'h1));
            // coherency on translated address
            d.o_coh    = ent_use[art_pkg::ENT_COH] & 1'b1;
            d.o_cancel = 1'b0;
            if (!ent_use[art_pkg::ENT_VALID]) begin
               d.o_cancel = 1'b1;
               d.o_addr   = 64'h0;
               d.err      = 1'b1;
               d.err_addr = q.cur_ent_addr;
               d.alert    = 1'b1;
               d.c_valid  = 1'b0;
            end
         end
      endcase
      if (!rst_b) begin
         d = '0;
         d.st     = art_pkg::ART_IDLE;
         d.pg_sel = art_pkg::PG_4K;
      end
   end

   always_ff @(posedge clock) begin
      q <= d;
   end

   //////////////////////////////////////////////////////////////////////////
   assign s_axi_awready = !q.aw_got;
   assign s_axi_wready  = !q.w_got;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign req_ready     = (q.st == art_pkg::ART_IDLE);
   assign out_valid     = q.o_valid;
   assign out_addr      = q.o_addr;
   assign out_write     = q.o_write;
   assign out_coherent  = q.o_coh;
   assign out_cancel    = q.o_cancel;
   assign fetch_valid   = q.f_valid;
   assign fetch_addr    = q.cur_ent_addr;
   assign error_alert   = q.alert;

   //////////////////////////////////////////////////////////////////////////
   property p_base_align;
      @(posedge clock) disable iff (!rst_b)
      (s_axi_arvalid && !q.rvalid && s_axi_araddr == art_pkg::OFS_BASE_LOW)
      |=> ((q.rdata & amask[31:0]) == 32'h0);
   endproperty
   a_base_align: assert property (p_base_align) else $error("base low bits not zero");

   property p_passthru;
      @(posedge clock) disable iff (!rst_b)
      (q.st == art_pkg::ART_IDLE && req_valid && !in_aper)
      |=> (out_valid && out_addr == $past(req_addr) && !out_cancel);
   endproperty
   a_passthru: assert property (p_passthru) else $error("outside access altered");

   property p_disabled;
      @(posedge clock) disable iff (!rst_b)
      (q.st == art_pkg::ART_IDLE && req_valid && !q.aper_en) |=> !fetch_valid;
   endproperty
   a_disabled: assert property (p_disabled) else $error("fetch with aperture off");

   sequence s_miss;
      q.st == art_pkg::ART_IDLE && req_valid && in_aper && !(q.cache_en && q.c_valid);
   endsequence
   property p_lookup;
      @(posedge clock) disable iff (!rst_b)
      s_miss |=> (fetch_valid && fetch_addr == $past(ent_addr));
   endproperty
   a_lookup: assert property (p_lookup) else $error("lookup not started");

   property p_err_latch;
      @(posedge clock) disable iff (!rst_b)
      (q.st == art_pkg::ART_DONE && !q.c_data[art_pkg::ENT_VALID])
      |=> (q.err && error_alert && out_cancel ##1 !error_alert);
   endproperty
   a_err_latch: assert property (p_err_latch) else $error("invalid entry not flagged");

   property p_write_cancel;
      @(posedge clock) disable iff (!rst_b)
      (out_valid && out_write && q.o_cancel) |-> (out_addr == 64'h0);
   endproperty
   a_write_cancel: assert property (p_write_cancel) else $error("cancel leaks addr");

   property p_err_hold;
      @(posedge clock) disable iff (!rst_b)
      (q.err && !(q.aw_got && q.w_got && q.aw_addr == art_pkg::OFS_ERR_FLAGS)) |=> q.err;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error bit dropped");

   property p_cache_off;
      @(posedge clock) disable iff (!rst_b)
      !q.cache_en |=> !q.c_valid;
   endproperty
   a_cache_off: assert property (p_cache_off) else $error("cache kept while disabled");

   property p_coh;
      @(posedge clock) disable iff (!rst_b)
      (q.st == art_pkg::ART_DONE) |=> (out_coherent == $past(q.c_data[art_pkg::ENT_COH]));
   endproperty
   a_coh: assert property (p_coh) else $error("coherency bit ignored");
endmodule : art_top

// file: tb/art_mem_model.sv
// memory model that answers table entry fetches
`timescale 1ns/1ns
module art_mem_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // entry fetch
   input  wire logic        fetch_valid,
   input  wire logic [63:0] fetch_addr,
   output logic             fetch_done,
   output logic [63:0]      fetch_data
);
   logic [63:0] mem [logic [63:0]]; // table kept in plain uncached storage
   int          wait_n;
   initial begin
      fetch_done = 1'b0;
      fetch_data = 64'h0;
      wait_n     = 0;
   end
   // data line toggles whenever no answer is presented
   always @(posedge clock) begin
      if (!rst_b || fetch_done || !fetch_valid) begin
         fetch_done <= 1'b0;
         fetch_data <= ~fetch_data;
         wait_n     <= $urandom_range(3);
      end else if (wait_n == 0) begin
         fetch_done <= 1'b1;
         fetch_data <= mem.exists(fetch_addr) ? mem[fetch_addr] : ~fetch_data;
      end else begin
         wait_n     <= wait_n - 1;
         fetch_data <= ~fetch_data;
      end
   end
endmodule : art_mem_model

// file: tb/aperture_remap_translation_test.sv
// self-checking bench for the aperture translator
`timescale 1ns/1ns
module aperture_remap_translation_test;
   logic        clock = 0, rst_b = 0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, sx;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r, bq;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, req_valid = 0, req_write = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        req_ready, out_valid, out_write, out_coherent, out_cancel;
   logic        fetch_valid, fetch_done, error_alert;
   logic [63:0] req_addr = '0, out_addr, fetch_addr, fetch_data, base, tbl, ca, a, e;
   int          n_errors = 0, checks_done = 0, pg, wide, aen, cen, cv;
   int          pl_t[3] = '{art_pkg::PG_LOG2_4K, art_pkg::PG_LOG2_64K, art_pkg::PG_LOG2_4M};

   art_top art_top_i (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .req_valid, .req_ready, .req_addr, .req_write, .out_valid, .out_addr,
      .out_write, .out_coherent, .out_cancel, .fetch_valid, .fetch_addr, .fetch_done,
      .fetch_data, .error_alert);
   art_mem_model art_mem_model_i (.clock, .rst_b, .fetch_valid, .fetch_addr, .fetch_done,
      .fetch_data);

   always #10 clock = ~clock;
   ////////////////////////////////////////////////////////////
   task final_report;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   task chk(input bit ok, input string m);
      checks_done++;
      if (!ok) begin
         n_errors++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask : chk

   task tmo;
      chk(1'b0, "wait limit ran out");
      final_report;
   endtask : tmo

   task axw(input logic [7:0] ad, input logic [31:0] wd);
      int   i;
      logic ra, rw, rb;
      @(posedge clock);
      s_axi_awaddr  <= ad;
      s_axi_wdata   <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(negedge clock);
         ra = s_axi_awready;
         rw = s_axi_wready;
         rb = s_axi_bvalid;
         bq = s_axi_bresp;
         @(posedge clock);
         if (ra === 1'b1) s_axi_awvalid <= 1'b0;
         if (rw === 1'b1) s_axi_wvalid <= 1'b0;
         if (rb === 1'b1) begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (i == 64) tmo;
   endtask : axw

   task axr(input logic [7:0] ad);
      int   i;
      logic ra, rv;
      @(posedge clock);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(negedge clock);
         ra = s_axi_arready;
         rv = s_axi_rvalid;
         d  = s_axi_rdata;
         r  = s_axi_rresp;
         @(posedge clock);
         if (ra === 1'b1) s_axi_arvalid <= 1'b0;
         if (rv === 1'b1) begin
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (i == 64) tmo;
   endtask : axr

   task rc(input logic [7:0] ad, input logic [31:0] x, input logic [31:0] m);
      axr(ad);
      chk((d & m) === x && r === art_pkg::RESP_OKAY, "register readback");
   endtask : rc

   function automatic logic [63:0] ent_addr(input logic [63:0] ad);
      return tbl + (((ad - base) >> pl_t[pg]) << (wide ? art_pkg::M_WIDE : art_pkg::M_NARROW));
   endfunction : ent_addr

   // one master access, checked against the bench model
   task acc(input logic [63:0] ad, input logic w);
      int          i;
      bit          f, al, ins, xf, xk, xc, rd, bz;
      logic [63:0] ea, fa, en, xo;
      ins = aen && ad >= base && ad < base + (64'h1 << 24);
      ea  = ent_addr(ad);
      en  = 64'h1;
      if (ins) en = art_mem_model_i.mem[ea];
      if (!wide) en[63:32] = 32'h0;
      xf = ins && !(cen && cv && ca == ea);
      xk = ins && !en[0];
      xc = ins ? en[1] : 1'b1;
      xo = ins ? ({en[63:32], en[11:4], en[31:12]} << pl_t[pg]) |
                 (ad & ((64'h1 << pl_t[pg]) - 64'h1)) : ad;
      f  = 0;
      al = 0;
      bz = 0;
      @(posedge clock);
      req_addr  <= ad;
      req_write <= w;
      req_valid <= 1'b1;
      for (i = 0; i < 64; i++) begin
         @(negedge clock);
         rd = req_ready;
         if (fetch_valid === 1'b1 && req_ready !== 1'b0) bz = 1;
         if (fetch_valid === 1'b1) f = 1;
         if (fetch_valid === 1'b1) fa = fetch_addr;
         if (error_alert === 1'b1) al = 1;
         if (out_valid === 1'b1) break;
         @(posedge clock);
         if (rd && req_valid) req_valid <= 1'b0;
      end
      if (i == 64) tmo;
      @(negedge clock);
      if (error_alert === 1'b1) al = 1;
      chk(f === xf, "entry fetch presence");
      chk(!bz, "request ready while fetching");
      if (xf) chk(fa === ea, "entry address");
      chk(out_cancel === xk && al === xk && out_write === w, "cancel or alert");
      if (!xk) chk(out_addr === xo && out_coherent === xc, "translated access");
      if (cen && xf) begin
         cv = !xk;
         ca = ea;
      end
      if (xk) begin
         rc(art_pkg::OFS_ERR_FLAGS, 32'h1, 32'h1);
         rc(art_pkg::OFS_ERR_ADDR_L, ea[31:0], 32'hffff_ffff);
         rc(art_pkg::OFS_ERR_ADDR_H, ea[63:32], 32'hffff_ffff);
         axw(art_pkg::OFS_ERR_FLAGS, 32'h1);
         rc(art_pkg::OFS_ERR_FLAGS, 32'h0, 32'h1);
      end
   endtask : acc
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clock);
      tmo;
   end

   initial begin
      void'($urandom(73));
      aen = 0;
      cen = 0;
      cv  = 0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      sx = (32'h1 << art_pkg::STA_HTRANS_B) | (32'h1 << art_pkg::STA_ITA_COH) |
           (32'h1 << art_pkg::STA_WIDE_OK) |
           (32'(art_pkg::PG_SUPPORT) << art_pkg::STA_PAGES_LSB);
      rc(art_pkg::OFS_STATUS, sx, sx);
      rc(art_pkg::OFS_PAGE_SEL, 32'h0, 32'h3);
      for (int n = 0; n <= 8; n++) begin
         axw(art_pkg::OFS_SIZE_SEL, 32'(n));
         axw(art_pkg::OFS_BASE_LOW, 32'hffff_ffff);
         rc(art_pkg::OFS_BASE_LOW, ~((32'h1 << (art_pkg::SIZE_LOG2_0 + n)) - 32'h1), '1);
      end
      axw(art_pkg::OFS_BASE_HIGH, 32'h1);
      chk(bq === art_pkg::RESP_OKAY, "write response");
      rc(art_pkg::OFS_BASE_HIGH, 32'h1, 32'hffff_ffff);
      axr(8'h3c);
      chk(r === art_pkg::RESP_SLVERR, "unmapped read response");
      axw(8'h3c, 32'h0);
      chk(bq === art_pkg::RESP_SLVERR, "unmapped write response");
      // 16 mb aperture above 4 gb, table with unaligned low bits
      axw(art_pkg::OFS_SIZE_SEL, 32'h2);
      axw(art_pkg::OFS_BASE_LOW, 32'h4000_0000);
      axw(art_pkg::OFS_TBL_LOW, 32'h1234_5abc);
      axw(art_pkg::OFS_TBL_HIGH, 32'h2);
      base = {32'h1, 32'h4000_0000};
      tbl  = {32'h2, 32'h1234_5000};
      pg   = 0;
      wide = 0;
      acc(base + 64'h1230, 1'b1);
      axw(art_pkg::OFS_CONTROL, 32'h1);
      aen = 1;
      acc(base - 64'h8, 1'b0);
      acc(base + (64'h1 << 24), 1'b1);
      for (pg = 0; pg < 3; pg++) begin
         for (wide = 0; wide < 2; wide++) begin
            axw(art_pkg::OFS_PAGE_SEL, 32'(pg));
            axw(art_pkg::OFS_COMMAND, 32'(wide));
            repeat (6) begin
               a = base + 64'($urandom & 32'h00ff_ffff);
               e = {24'h0, 8'($urandom), 32'($urandom) & 32'hffff_fff2} | 64'($urandom % 4 != 0);
               art_mem_model_i.mem[ent_addr(a)] = e;
               acc(a, 1'($urandom));
            end
         end
      end
      pg   = 1;
      wide = 1;
      axw(art_pkg::OFS_PAGE_SEL, 32'h1);
      a = base + 64'h2_0010;
      art_mem_model_i.mem[ent_addr(a)] = 64'h0000_0003_5555_5013;
      acc(a, 1'b0);
      acc(a, 1'b1);
      axw(art_pkg::OFS_CONTROL, 32'h3);
      cen = 1;
      acc(a, 1'b0);
      acc(a + 64'h4, 1'b1);
      art_mem_model_i.mem[ent_addr(a + 64'h1_0000)] = 64'h0000_0003_5555_5011;
      acc(a + 64'h1_0000, 1'b0);
      // entry rewrite with the cache switched off around it
      axw(art_pkg::OFS_CONTROL, 32'h1);
      cen = 0;
      cv  = 0;
      art_mem_model_i.mem[ent_addr(a)] = 64'h0000_0004_aaaa_a061;
      axw(art_pkg::OFS_CONTROL, 32'h3);
      cen = 1;
      acc(a, 1'b0);
      rc(art_pkg::OFS_HITS, 32'h1, 32'hffff_ffff);
      final_report;
   end
endmodule : aperture_remap_translation_test
